/* csk_pkg.sv */
`default_nettype none
package csk_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SIDETONE   = 7'h03;
    localparam logic [6:0] ADDR_AUDIO_TWO  = 7'h04;

    localparam int ST_ANALOG_MUTE  = 15;
    localparam int ST_ANALOG_HI    = 14;
    localparam int ST_ANALOG_LO    = 8;
    localparam int ST_DIGITAL_MUTE = 7;
    localparam int ST_DIGITAL_HI   = 6;
    localparam int ST_DIGITAL_LO   = 1;
    localparam int ST_ANALOG_DONE  = 0;

    localparam int A2_CLICK_EN     = 15;
    localparam int A2_AMP_HI       = 14;
    localparam int A2_AMP_LO       = 12;
    localparam int A2_ADC_RATE     = 11;
    localparam int A2_FREQ_HI      = 10;
    localparam int A2_FREQ_LO      = 8;
    localparam int A2_LEN_HI       = 7;
    localparam int A2_LEN_LO       = 4;
    localparam int A2_DL_DONE      = 3;
    localparam int A2_DR_DONE      = 2;
    localparam int A2_DAC_RATE     = 1;
    localparam int A2_ADC_DONE     = 0;

    // ------------------------------------------------------------
    // reset values and decode limits
    // ------------------------------------------------------------
    localparam logic [6:0] ANALOG_GAIN_RST = 7'h45;
    localparam logic [6:0] ANALOG_GAIN_MAX = 7'h5D;
    localparam logic [5:0] DIGITAL_ATT_MAX = 6'h20;
    localparam logic [2:0] CLICK_AMP_RST   = 3'h4;
    localparam logic [2:0] CLICK_FREQ_RST  = 3'h4;
    localparam logic [3:0] CLICK_LEN_RST   = 4'h1;
    localparam logic [15:0] RDATA_RST      = 16'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 8;
    localparam int CLICK_BASE_PER_NS  = 16_000_000;
    localparam int CLICK_HALF_CYCLES  = CLICK_BASE_PER_NS / (2 * CLK_PERIOD_NS);
    localparam int CLICK_TIMER_W      = 20;

    typedef struct packed {
        logic       analog_mute;
        logic [6:0] analog_gain;
        logic       digital_mute;
        logic [5:0] digital_gain;
    } csk_side_t;

    typedef struct packed {
        logic       enable;
        logic [2:0] amplitude;
        logic [2:0] frequency;
        logic [3:0] length;
        logic       adc_rate;
        logic       dac_rate;
    } csk_audio_t;

    typedef enum logic {CLICK_IDLE, CLICK_RUN} csk_click_state_t;
endpackage
`default_nettype wire

/* csk_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - analog mute bit 15 mutes, resets one
// - analog gain code saturates at 12dB
// - digital mute bit 7 mutes, resets one
// - digital gain 1.5dB steps, top bit -48dB
// - digital gain applied at zero crossing
// - analog gain applied at zero crossing
// - bit 0 flags analog gain applied
// - click enable starts tone, self clears
// - click amplitude three-bit, resets medium
// - click frequency 62.5Hz doubling per code
// - click lasts two times code-plus-one periods
// - adc step every one or two frames
// - with agc bit 11 reports noise
// - dac step every one or two frames
// - bit 3 flags left dac done
// - bit 2 flags right dac done
// - bit 0 flags adc stepping done
// - with agc bit 0 reports saturation
// - agc enable hands adc gain over
// - word-select pin or hardware power-down
module csk_ctrl
    import csk_pkg::*;
#(
    parameter int CLICK_HALF = CLICK_HALF_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        reg_write_i,
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        dac_word_clock_i,
    input  wire logic        adc_word_select_i,
    input  wire logic        analog_zero_cross_i,
    input  wire logic        digital_zero_cross_i,
    input  wire logic [6:0]  dac_left_target_i,
    input  wire logic [6:0]  dac_right_target_i,
    input  wire logic [6:0]  adc_target_i,
    input  wire logic        auto_gain_on_i,
    input  wire logic        adc_ws_pin_function_i,
    input  wire logic [6:0]  agc_gain_i,
    input  wire logic        agc_noise_low_i,
    input  wire logic        agc_saturated_i,
    output logic             analog_side_mute_o,
    output logic      [6:0]  analog_side_gain_o,
    output logic             digital_side_mute_o,
    output logic      [5:0]  digital_side_atten_o,
    output logic             click_tone_o,
    output logic      [2:0]  click_amplitude_o,
    output logic      [6:0]  dac_left_gain_o,
    output logic      [6:0]  dac_right_gain_o,
    output logic      [6:0]  adc_gain_o,
    output logic             adc_hw_powerdown_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] step_toward(input logic [6:0] cur, input logic [6:0] tgt);
        if (cur < tgt) begin
            return 7'(cur + 7'h01);
        end else if (cur > tgt) begin
            return 7'(cur - 7'h01);
        end
        return cur;
    endfunction

    function automatic logic [6:0] analog_sat(input logic [6:0] code);
        return (code > ANALOG_GAIN_MAX) ? ANALOG_GAIN_MAX : code;
    endfunction

    function automatic logic [5:0] digital_att(input logic [5:0] code);
        return code[5] ? DIGITAL_ATT_MAX : code;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_last_q;
    logic [3:0] pin_rise;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_last_q <= 4'h0;
        end else begin
            pin_meta_q <= {digital_zero_cross_i, analog_zero_cross_i,
                           adc_word_select_i, dac_word_clock_i};
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
        end
    end

    assign pin_rise = pin_sync_q & ~pin_last_q;

    logic dac_edge;
    logic adc_edge;
    logic az_edge;
    logic dz_edge;
    assign dac_edge = pin_rise[0];
    assign adc_edge = adc_ws_pin_function_i ? pin_rise[1] : pin_rise[0];
    assign az_edge  = pin_rise[2];
    assign dz_edge  = pin_rise[3];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    csk_side_t        side_q;
    csk_audio_t       aud_q;
    logic             wr_side;
    logic             wr_aud;
    logic             click_end;
    csk_click_state_t click_state_q;

    assign wr_side = reg_write_i && (reg_addr_i == ADDR_SIDETONE);
    assign wr_aud  = reg_write_i && (reg_addr_i == ADDR_AUDIO_TWO);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            side_q.analog_mute  <= 1'b1;
            side_q.analog_gain  <= ANALOG_GAIN_RST;
            side_q.digital_mute <= 1'b1;
            side_q.digital_gain <= '0;
        end else if (wr_side) begin
            side_q.analog_mute  <= reg_wdata_i[ST_ANALOG_MUTE];
            side_q.analog_gain  <= reg_wdata_i[ST_ANALOG_HI:ST_ANALOG_LO];
            side_q.digital_mute <= reg_wdata_i[ST_DIGITAL_MUTE];
            side_q.digital_gain <= reg_wdata_i[ST_DIGITAL_HI:ST_DIGITAL_LO];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            aud_q.enable    <= 1'b0;
            aud_q.amplitude <= CLICK_AMP_RST;
            aud_q.frequency <= CLICK_FREQ_RST;
            aud_q.length    <= CLICK_LEN_RST;
            aud_q.adc_rate  <= 1'b0;
            aud_q.dac_rate  <= 1'b0;
        end else begin
            if (wr_aud) begin
                aud_q.amplitude <= reg_wdata_i[A2_AMP_HI:A2_AMP_LO];
                aud_q.frequency <= reg_wdata_i[A2_FREQ_HI:A2_FREQ_LO];
                aud_q.length    <= reg_wdata_i[A2_LEN_HI:A2_LEN_LO];
                aud_q.dac_rate  <= reg_wdata_i[A2_DAC_RATE];
                if (!auto_gain_on_i) begin
                    aud_q.adc_rate <= reg_wdata_i[A2_ADC_RATE];
                end
            end
            // enable: software set wins over the self clear
            if (wr_aud && reg_wdata_i[A2_CLICK_EN]) begin
                aud_q.enable <= 1'b1;
            end else if (click_end) begin
                aud_q.enable <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sidetone gain application
    // ------------------------------------------------------------
    logic [6:0] ast_app_q;
    logic [5:0] dst_app_q;
    logic       ast_done_q;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ast_app_q <= '0;
        end else if (az_edge) begin
            ast_app_q <= analog_sat(side_q.analog_gain);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            dst_app_q <= '0;
        end else if (dz_edge) begin
            dst_app_q <= side_q.digital_gain;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ast_done_q <= 1'b0;
        end else begin
            ast_done_q <= (ast_app_q == analog_sat(side_q.analog_gain));
        end
    end

    // ------------------------------------------------------------
    // soft-stepping
    // ------------------------------------------------------------
    logic       dac_div_q;
    logic       adc_div_q;
    logic       dac_tick;
    logic       adc_tick;
    logic [6:0] dac_left_q;
    logic [6:0] dac_right_q;
    logic [6:0] adc_q;
    logic       dl_done_q;
    logic       dr_done_q;
    logic       adc_done_q;

    assign dac_tick = dac_edge && (!aud_q.dac_rate || dac_div_q);
    assign adc_tick = adc_edge && (!aud_q.adc_rate || adc_div_q);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            dac_div_q <= 1'b0;
            adc_div_q <= 1'b0;
        end else begin
            dac_div_q <= dac_edge ? !dac_div_q : dac_div_q;
            adc_div_q <= adc_edge ? !adc_div_q : adc_div_q;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            dac_left_q  <= '0;
            dac_right_q <= '0;
        end else if (dac_tick) begin
            dac_left_q  <= step_toward(dac_left_q, dac_left_target_i);
            dac_right_q <= step_toward(dac_right_q, dac_right_target_i);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            adc_q <= '0;
        end else if (auto_gain_on_i) begin
            adc_q <= agc_gain_i;
        end else if (adc_tick) begin
            adc_q <= step_toward(adc_q, adc_target_i);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            dl_done_q  <= 1'b0;
            dr_done_q  <= 1'b0;
            adc_done_q <= 1'b0;
        end else begin
            dl_done_q  <= (dac_left_q == dac_left_target_i);
            dr_done_q  <= (dac_right_q == dac_right_target_i);
            adc_done_q <= auto_gain_on_i ? agc_saturated_i
                                         : (adc_q == adc_target_i);
        end
    end

    // ------------------------------------------------------------
    // keyclick generator
    // ------------------------------------------------------------
    logic [CLICK_TIMER_W-1:0] half_cnt_q;
    logic [CLICK_TIMER_W-1:0] half_load;
    logic [6:0]               halves_q;
    logic                     tone_q;
    logic                     click_start;

    assign half_load   = CLICK_TIMER_W'(CLICK_HALF >> aud_q.frequency);
    assign click_start = (click_state_q == CLICK_IDLE) && aud_q.enable;
    assign click_end   = (click_state_q == CLICK_RUN) && (half_cnt_q == '0)
                         && (halves_q == 7'h01);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            click_state_q <= CLICK_IDLE;
            half_cnt_q    <= '0;
            halves_q      <= '0;
            tone_q        <= 1'b0;
        end else begin
            unique case (click_state_q)
                CLICK_IDLE: begin
                    tone_q <= 1'b0;
                    if (click_start) begin
                        click_state_q <= CLICK_RUN;
                        half_cnt_q    <= 20'(half_load - 20'h00001);
                        halves_q      <= 7'({3'b000, aud_q.length, 2'b00} + 9'h004);
                    end
                end
                CLICK_RUN: begin
                    if (half_cnt_q != '0) begin
                        half_cnt_q <= 20'(half_cnt_q - 20'h00001);
                    end else if (halves_q == 7'h01) begin
                        click_state_q <= CLICK_IDLE;
                        tone_q        <= 1'b0;
                    end else begin
                        half_cnt_q <= 20'(half_load - 20'h00001);
                        halves_q   <= 7'(halves_q - 7'h01);
                        tone_q     <= !tone_q;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs and read-back
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            analog_side_mute_o   <= 1'b1;
            analog_side_gain_o   <= '0;
            digital_side_mute_o  <= 1'b1;
            digital_side_atten_o <= '0;
            click_tone_o         <= 1'b0;
            click_amplitude_o    <= CLICK_AMP_RST;
            dac_left_gain_o      <= '0;
            dac_right_gain_o     <= '0;
            adc_gain_o           <= '0;
            adc_hw_powerdown_o   <= 1'b0;
        end else begin
            analog_side_mute_o   <= side_q.analog_mute;
            analog_side_gain_o   <= ast_app_q;
            digital_side_mute_o  <= side_q.digital_mute;
            digital_side_atten_o <= digital_att(dst_app_q);
            click_tone_o         <= tone_q;
            click_amplitude_o    <= aud_q.amplitude;
            dac_left_gain_o      <= dac_left_q;
            dac_right_gain_o     <= dac_right_q;
            adc_gain_o           <= adc_q;
            adc_hw_powerdown_o   <= !adc_ws_pin_function_i && pin_sync_q[1];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= RDATA_RST;
        end else if (reg_addr_i == ADDR_SIDETONE) begin
            reg_rdata_o <= {side_q.analog_mute, side_q.analog_gain, side_q.digital_mute,
                            side_q.digital_gain, ast_done_q};
        end else if (reg_addr_i == ADDR_AUDIO_TWO) begin
            reg_rdata_o <= {aud_q.enable, aud_q.amplitude,
                            auto_gain_on_i ? agc_noise_low_i : aud_q.adc_rate,
                            aud_q.frequency, aud_q.length, dl_done_q, dr_done_q,
                            aud_q.dac_rate, adc_done_q};
        end else begin
            reg_rdata_o <= RDATA_RST;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_side_write_mute;
        wr_side && reg_wdata_i[ST_ANALOG_MUTE] ##1 !wr_side;
    endsequence

    sequence s_click_last_half;
        click_end && !(wr_aud && reg_wdata_i[A2_CLICK_EN]);
    endsequence

    AST_ANALOG_MUTE: assert property (s_side_write_mute |=> analog_side_mute_o)
        else $error("analog mute not applied after write");
    AST_ANALOG_ZERO: assert property ($changed(ast_app_q) |-> $past(az_edge))
        else $error("analog gain changed off a zero crossing");
    AST_ANALOG_SAT: assert property (ast_app_q <= ANALOG_GAIN_MAX)
        else $error("analog gain above saturation code");
    AST_DIGITAL_ZERO: assert property ($changed(dst_app_q) |-> $past(dz_edge))
        else $error("digital gain changed off a zero crossing");
    AST_DIGITAL_ATT: assert property (dst_app_q[5] |=> digital_side_atten_o == DIGITAL_ATT_MAX)
        else $error("digital gain not forced to minimum");
    AST_CLICK_CLEAR: assert property (s_click_last_half |=> !aud_q.enable && !tone_q)
        else $error("click enable not self cleared");
    AST_DAC_STEP: assert property ($changed(dac_left_q) |-> $past(dac_tick))
        else $error("dac gain moved without a frame tick");
    AST_ADC_STEP: assert property (!auto_gain_on_i && $changed(adc_q) && !$past(auto_gain_on_i)
                                   |-> $past(adc_tick))
        else $error("adc gain moved without a frame tick");
    AST_STEP_SIZE: assert property ($changed(dac_right_q) |->
                                    (dac_right_q == 7'($past(dac_right_q) + 7'h01)) ||
                                    (dac_right_q == 7'($past(dac_right_q) - 7'h01)))
        else $error("dac gain moved by more than one code");
    AST_ADC_RATE_LOCK: assert property (auto_gain_on_i && wr_aud |=> $stable(aud_q.adc_rate))
        else $error("adc step rate written while agc on");
    AST_AGC_FOLLOW: assert property (auto_gain_on_i |=> adc_q == $past(agc_gain_i))
        else $error("adc gain not following agc loop");

endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import csk_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clock_i, resetn_i, reg_write_i;
    logic [6:0]  reg_addr_i, dac_left_target_i, dac_right_target_i, adc_target_i, agc_gain_i;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic        dac_word_clock_i, adc_word_select_i, analog_zero_cross_i, digital_zero_cross_i;
    logic        auto_gain_on_i, adc_ws_pin_function_i, agc_noise_low_i, agc_saturated_i;
    logic        analog_side_mute_o, digital_side_mute_o, click_tone_o, adc_hw_powerdown_o;
    logic [6:0]  analog_side_gain_o, dac_left_gain_o, dac_right_gain_o, adc_gain_o;
    logic [5:0]  digital_side_atten_o;
    logic [2:0]  click_amplitude_o, amp;
    logic        tone_q;
    int          miscompares, checks_done, cycles, rises, highs, half, len;

    csk_ctrl #(.CLICK_HALF(256)) i_dut (.*);

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_write_i <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [6:0] a, input logic [15:0] m,
                        input logic [15:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        chk(nm, e, reg_rdata_o & m);
    endtask
    task automatic pin(input int w);
        @(posedge clock_i);
        case (w)
            0: analog_zero_cross_i <= 1'b1;
            1: digital_zero_cross_i <= 1'b1;
            2: dac_word_clock_i <= 1'b1;
            default: adc_word_select_i <= 1'b1;
        endcase
        repeat (3) @(posedge clock_i);
        analog_zero_cross_i  <= 1'b0;
        digital_zero_cross_i <= 1'b0;
        dac_word_clock_i     <= 1'b0;
        adc_word_select_i    <= 1'b0;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    task automatic tdone(input string nm);
        $display("test %0s finished", nm);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // tone counter and timeout
    // ----------------------------------------
    always @(posedge clock_i) begin
        tone_q <= click_tone_o;
        if (click_tone_o === 1'b1 && tone_q === 1'b0) rises++;
        if (click_tone_o === 1'b1) highs++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        resetn_i = 1'b0; reg_write_i = 1'b0; reg_addr_i = 7'h00; reg_wdata_i = 16'h0000;
        dac_word_clock_i = 1'b0; adc_word_select_i = 1'b0; analog_zero_cross_i = 1'b0;
        digital_zero_cross_i = 1'b0; dac_left_target_i = 7'h03; dac_right_target_i = 7'h02;
        adc_target_i = 7'h04; auto_gain_on_i = 1'b0; adc_ws_pin_function_i = 1'b1;
        agc_gain_i = 7'h00; agc_noise_low_i = 1'b0; agc_saturated_i = 1'b0;
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        chk("mutes", 16'h0003, {14'h0, analog_side_mute_o, digital_side_mute_o});
        chk("amplitude", 16'h0004, {13'h0, click_amplitude_o});
        rchk("side reset", ADDR_SIDETONE, 16'hFFFF, 16'hC580);
        rchk("audio reset", ADDR_AUDIO_TWO, 16'hFFFF, 16'h4410);
        rchk("unmapped", 7'h05, 16'hFFFF, 16'h0000);
        tdone("reset");

        wr(ADDR_SIDETONE, 16'h7F4B);
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        chk("mutes off", 16'h0000, {14'h0, analog_side_mute_o, digital_side_mute_o});
        chk("analog held", 16'h0000, {9'h0, analog_side_gain_o});
        chk("digital held", 16'h0000, {10'h0, digital_side_atten_o});
        rchk("side read", ADDR_SIDETONE, 16'hFFFF, 16'h7F4A);
        pin(0);
        chk("analog sat", 16'h005D, {9'h0, analog_side_gain_o});
        rchk("analog flag", ADDR_SIDETONE, 16'h0001, 16'h0001);
        chk("digital wait", 16'h0000, {10'h0, digital_side_atten_o});
        pin(1);
        chk("digital floor", 16'h0020, {10'h0, digital_side_atten_o});
        wr(ADDR_SIDETONE, 16'h8086);
        rchk("flag drop", ADDR_SIDETONE, 16'h0001, 16'h0000);
        chk("mutes on", 16'h0003, {14'h0, analog_side_mute_o, digital_side_mute_o});
        pin(1);
        chk("digital step", 16'h0003, {10'h0, digital_side_atten_o});
        tdone("sidetone");

        for (int k = 1; k <= 4; k++) begin
            pin(2);
            chk("dac left", 16'((k > 3) ? 3 : k), {9'h0, dac_left_gain_o});
            chk("dac right", 16'((k > 2) ? 2 : k), {9'h0, dac_right_gain_o});
        end
        rchk("dac flags", ADDR_AUDIO_TWO, 16'h000C, 16'h000C);
        dac_left_target_i <= 7'h07;
        wr(ADDR_AUDIO_TWO, 16'h441E);
        rchk("left busy", ADDR_AUDIO_TWO, 16'h000F, 16'h0006);
        repeat (4) pin(2);
        chk("dac half rate", 16'h0005, {9'h0, dac_left_gain_o});
        tdone("dac");

        repeat (2) pin(3);
        chk("adc full rate", 16'h0002, {9'h0, adc_gain_o});
        wr(ADDR_AUDIO_TWO, 16'h4C10);
        rchk("adc rate bit", ADDR_AUDIO_TWO, 16'h0801, 16'h0800);
        repeat (4) pin(3);
        chk("adc half rate", 16'h0004, {9'h0, adc_gain_o});
        rchk("adc done", ADDR_AUDIO_TWO, 16'h0001, 16'h0001);
        auto_gain_on_i <= 1'b1;
        agc_gain_i <= 7'h33;
        agc_noise_low_i <= 1'b1;
        agc_saturated_i <= 1'b1;
        rchk("agc flags", ADDR_AUDIO_TWO, 16'h0801, 16'h0801);
        chk("agc gain", 16'h0033, {9'h0, adc_gain_o});
        agc_noise_low_i <= 1'b0;
        agc_saturated_i <= 1'b0;
        wr(ADDR_AUDIO_TWO, 16'h4410);
        rchk("agc clear", ADDR_AUDIO_TWO, 16'h0801, 16'h0000);
        auto_gain_on_i <= 1'b0;
        rchk("rate kept", ADDR_AUDIO_TWO, 16'h0800, 16'h0800);
        adc_ws_pin_function_i <= 1'b0;
        adc_word_select_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        chk("powerdown", 16'h0001, {15'h0, adc_hw_powerdown_o});
        adc_word_select_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        chk("powerup", 16'h0000, {15'h0, adc_hw_powerdown_o});
        tdone("adc");

        for (int k = 0; k < 3; k++) begin
            amp = (k == 0) ? 3'h0 : ((k == 1) ? 3'h4 : 3'h7);
            half = 256 >> (7 - k);
            len = k;
            rises = 0;
            highs = 0;
            wr(ADDR_AUDIO_TWO, {1'b1, amp, 1'b0, 3'(7 - k), 4'(len), 4'h0});
            if (k == 2) begin
                repeat (6) @(posedge clock_i);
                wr(ADDR_AUDIO_TWO, {1'b0, amp, 1'b0, 3'(7 - k), 4'hF, 4'h0});
            end
            rchk("click on", ADDR_AUDIO_TWO, 16'h8000, 16'h8000);
            repeat (200) @(posedge clock_i);
            chk("amp out", 16'(amp), {13'h0, click_amplitude_o});
            chk("periods", 16'(2 * (len + 1)), 16'(rises));
            chk("high time", 16'(half * 2 * (len + 1)), 16'(highs));
            rchk("click off", ADDR_AUDIO_TWO, 16'h8000, 16'h0000);
        end
        tdone("keyclick");
        end_sim();
    end
endmodule
`default_nettype wire
